// >>> verilog/scan_seq_pkg.sv
// constants and types shared by the linear pixel array scan sequencer
package scan_seq_pkg;
   // array organisation
   localparam int unsigned SECTIONS = 2;
   localparam int unsigned DATA_W = 12;
   localparam int unsigned FIFO_DEPTH = 16;
   localparam int unsigned CNT_W = 11;
   localparam int unsigned PIXELS = 640;
   localparam int unsigned RESET_CLKS = 18;
   // shift clock edge numbers, the capturing edge is edge one
   localparam logic [CNT_W-1:0] CNT_FIRST = 11'h001;
   localparam logic [CNT_W-1:0] CNT_CARRY = CNT_W'(PIXELS);
   localparam logic [CNT_W-1:0] CNT_INTEG = CNT_W'(RESET_CLKS + 1);
   // width of the synchronised input group
   localparam int unsigned SYNC_W = 7;
   // bit positions inside the synchronised input group
   localparam int unsigned SY_CLK = 0;
   localparam int unsigned SY_START = 2;
   localparam int unsigned SY_FRZ = 4;
   localparam int unsigned SY_SERIAL = 6;
   // readout phase of one section
   typedef enum logic [2:0] {
      PH_IDLE = 3'b001,
      PH_READ = 3'b010,
      PH_CARRY = 3'b100
   } phase_t;
endpackage : scan_seq_pkg

// >>> verilog/sync_two_ff.sv
// two flip-flop synchroniser for a group of asynchronous level inputs
`timescale 1ns/1ps
module sync_two_ff #(
   parameter int unsigned W = 1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic en_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_state_t;

   sync_state_t r;
   sync_state_t r_nxt;

   // first stage feeds only the second stage
   always_comb begin
      r_nxt = r;
      if (en_i) begin
         r_nxt.s1 = async_i;
         r_nxt.s2 = r.s1;
      end
   end

   // state register
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         r <= '0;
      end else begin
         r <= r_nxt;
      end
   end

   assign sync_o = r.s2;
endmodule : sync_two_ff

// >>> verilog/pixel_fifo.sv
// flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
module pixel_fifo #(
   parameter int unsigned W = 12,
   parameter int unsigned DEPTH = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic en_i,
   input wire logic [W-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   output logic [W-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   localparam int unsigned AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
   } fifo_state_t;

   fifo_state_t r;
   fifo_state_t r_nxt;
   logic push;
   logic pop;

   // honest full and empty from the fill count
   assign in_ready_o = (r.cnt != FULL);
   assign out_valid_o = (r.cnt != '0);
   assign out_data_o = r.mem[r.rd];
   assign push = en_i && in_valid_i && in_ready_o;
   assign pop = en_i && out_valid_o && out_ready_i;

   // write, read and count update
   always_comb begin
      r_nxt = r;
      if (push) begin
         r_nxt.mem[r.wr] = in_data_i;
         r_nxt.wr = (r.wr == LAST) ? '0 : r.wr + 1'b1;
      end
      if (pop) begin
         r_nxt.rd = (r.rd == LAST) ? '0 : r.rd + 1'b1;
      end
      if (push && !pop) begin
         r_nxt.cnt = r.cnt + 1'b1;
      end else if (pop && !push) begin
         r_nxt.cnt = r.cnt - 1'b1;
      end
   end

   // state register
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         r <= '0;
      end else begin
         r <= r_nxt;
      end
   end
endmodule : pixel_fifo

// >>> verilog/linear_pixel_array_scan_sequencer.sv
// scan and readout sequencer for a two-section linear pixel array
//
// Function
// - each section holds a 640-stage scan selecting readout pixel and integrator reset
// - freeze strobe rising edge disconnects all samples and begins integrator reset
// - start pulse walks through the section, one pixel value driven per clock
// - integrator reset ends 18 clocks after start capture, integration then begins
// - carry output goes high on the 640th rising clock edge after start
// - 641st rising edge ends carry and returns the section output to high impedance
// - serial chaining: second carry rises on clock 1280 from the original start
// - section output is high impedance outside its output phase
// - serial mode: first carry starts section two, first freeze feeds second freeze
// - second carry usable as cascade start or end-of-data indication
// - freeze transfers all samples at once, sharing integration start and stop
// - each section's own shift clock governs output and integrator reset end; transfer follows the freeze strobe
`timescale 1ns/1ps
module linear_pixel_array_scan_sequencer (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic en_i,
   input wire logic chain_serial_i,
   input wire logic section1_shift_clock_i,
   input wire logic section2_shift_clock_i,
   input wire logic section1_scan_start_in_i,
   input wire logic section2_scan_start_in_i,
   input wire logic section1_freeze_strobe_i,
   input wire logic section2_freeze_strobe_i,
   input wire logic [scan_seq_pkg::DATA_W-1:0] section1_sample_data_i,
   input wire logic section1_sample_valid_i,
   output logic section1_sample_ready_o,
   input wire logic [scan_seq_pkg::DATA_W-1:0] section2_sample_data_i,
   input wire logic section2_sample_valid_i,
   output logic section2_sample_ready_o,
   output logic [scan_seq_pkg::DATA_W-1:0] section1_pixel_voltage_out_o,
   output logic section1_pixel_voltage_oe_o,
   output logic [scan_seq_pkg::DATA_W-1:0] section2_pixel_voltage_out_o,
   output logic section2_pixel_voltage_oe_o,
   output logic section1_scan_carry_out_o,
   output logic section2_scan_carry_out_o,
   output logic section1_hold_pulse_o,
   output logic section2_hold_pulse_o,
   output logic section1_integrating_o,
   output logic section2_integrating_o,
   output logic section1_underrun_o,
   output logic section2_underrun_o
);
   localparam int unsigned NS = scan_seq_pkg::SECTIONS;
   localparam int unsigned DW = scan_seq_pkg::DATA_W;
   localparam int unsigned CW = scan_seq_pkg::CNT_W;

   // per-section sequencing state
   typedef struct packed {
      scan_seq_pkg::phase_t phase;
      logic [CW-1:0] cnt;
      logic in_reset;
      logic integ;
      logic out_en;
      logic carry;
      logic hold;
      logic underrun;
      logic [DW-1:0] data;
   } sec_t;

   // whole module state
   typedef struct packed {
      sec_t [NS-1:0] sec;
      logic [NS-1:0] clk_prev;
      logic [NS-1:0] frz_prev;
   } state_t;

   localparam sec_t SEC_RST = '{
      phase: scan_seq_pkg::PH_IDLE,
      cnt: '0,
      in_reset: 1'b0,
      integ: 1'b0,
      out_en: 1'b0,
      carry: 1'b0,
      hold: 1'b0,
      underrun: 1'b0,
      data: '0
   };
   localparam state_t STATE_RST = '{
      sec: {NS{SEC_RST}},
      clk_prev: '0,
      frz_prev: '0
   };

   // registered state and its next value
   state_t r;
   state_t r_nxt;

   // controller pins before and after the synchroniser
   logic [scan_seq_pkg::SYNC_W-1:0] raw_in;
   logic [scan_seq_pkg::SYNC_W-1:0] sy;

   // synchronised pins by section
   logic [NS-1:0] clk_s;
   logic [NS-1:0] start_s;
   logic [NS-1:0] frz_s;
   logic serial_s;

   // sample stream into each section's buffer
   logic [NS-1:0][DW-1:0] smp_data;
   logic [NS-1:0] smp_valid;
   logic [NS-1:0] smp_ready;

   // buffer read side, popped once per pixel
   logic [NS-1:0][DW-1:0] fifo_data;
   logic [NS-1:0] fifo_valid;
   logic [NS-1:0] pop_req;

   // per-section views of the output flops
   logic [NS-1:0][DW-1:0] pix_q;
   logic [NS-1:0] oe_q;
   logic [NS-1:0] carry_q;
   logic [NS-1:0] hold_q;
   logic [NS-1:0] integ_q;
   logic [NS-1:0] under_q;

   // all pins from the controller cross into clk_i through two flops
   // start and clock share one path, so start is seen against the same clock level
   assign raw_in = {chain_serial_i,
                    section2_freeze_strobe_i, section1_freeze_strobe_i,
                    section2_scan_start_in_i, section1_scan_start_in_i,
                    section2_shift_clock_i, section1_shift_clock_i};

   sync_two_ff #(
      .W(scan_seq_pkg::SYNC_W)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .en_i(en_i),
      .async_i(raw_in),
      .sync_o(sy)
   );

   // split the synchronised group
   assign clk_s = sy[scan_seq_pkg::SY_CLK +: NS];
   assign start_s = sy[scan_seq_pkg::SY_START +: NS];
   assign frz_s = sy[scan_seq_pkg::SY_FRZ +: NS];
   assign serial_s = sy[scan_seq_pkg::SY_SERIAL];

   // sample streams gathered by section
   assign smp_data[0] = section1_sample_data_i;
   assign smp_data[1] = section2_sample_data_i;
   assign smp_valid[0] = section1_sample_valid_i;
   assign smp_valid[1] = section2_sample_valid_i;
   assign section1_sample_ready_o = smp_ready[0];
   assign section2_sample_ready_o = smp_ready[1];

   // one pixel buffer per section, drained one word per output clock
   // a missing word never stalls the scan: the last word is held, underrun flagged
   for (genvar s = 0; s < NS; s++) begin : g_buf
      pixel_fifo #(
         .W(DW),
         .DEPTH(scan_seq_pkg::FIFO_DEPTH)
      ) u_fifo (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .en_i(en_i),
         .in_data_i(smp_data[s]),
         .in_valid_i(smp_valid[s]),
         .in_ready_o(smp_ready[s]),
         .out_data_o(fifo_data[s]),
         .out_valid_o(fifo_valid[s]),
         .out_ready_i(pop_req[s])
      );
   end

   // sequencing of both sections
   always_comb begin
      logic edge_s;
      logic start_eff;
      logic frz_eff;
      logic frz_rise;
      logic [CW-1:0] cnt_inc;
      r_nxt = r;
      pop_req = '0;
      edge_s = 1'b0;
      start_eff = 1'b0;
      frz_eff = 1'b0;
      frz_rise = 1'b0;
      cnt_inc = '0;
      for (int s = 0; s < NS; s++) begin
         // each section runs on edges of its own shift clock
         edge_s = clk_s[s] && !r.clk_prev[s];
         start_eff = start_s[s];
         frz_eff = frz_s[s];
         // serial chaining: section two follows section one, its own start and freeze pins ignored
         if (s == 1 && serial_s) begin
            start_eff = r.sec[0].carry;
            frz_eff = frz_s[0];
         end
         frz_rise = frz_eff && !r.frz_prev[s];
         cnt_inc = r.sec[s].cnt + 1'b1;
         r_nxt.clk_prev[s] = clk_s[s];
         r_nxt.frz_prev[s] = frz_eff;
         r_nxt.sec[s].hold = 1'b0;
         // freeze: latch every sample at once and restart integrator reset
         if (frz_rise) begin
            r_nxt.sec[s].hold = 1'b1;
            r_nxt.sec[s].in_reset = 1'b1;
            r_nxt.sec[s].integ = 1'b0;
         end
         if (edge_s) begin
            if (start_eff) begin
               // start captured: this edge is edge one, pixel one out
               r_nxt.sec[s].phase = scan_seq_pkg::PH_READ;
               r_nxt.sec[s].cnt = scan_seq_pkg::CNT_FIRST;
               r_nxt.sec[s].out_en = 1'b1;
               r_nxt.sec[s].carry = 1'b0;
               r_nxt.sec[s].underrun = 1'b0;
               pop_req[s] = 1'b1;
            end else begin
               unique case (r.sec[s].phase)
                  scan_seq_pkg::PH_IDLE: begin
                     r_nxt.sec[s].out_en = 1'b0;
                  end
                  scan_seq_pkg::PH_READ: begin
                     r_nxt.sec[s].cnt = cnt_inc;
                     pop_req[s] = 1'b1;
                     if (cnt_inc == scan_seq_pkg::CNT_CARRY) begin
                        r_nxt.sec[s].carry = 1'b1;
                        r_nxt.sec[s].phase = scan_seq_pkg::PH_CARRY;
                     end
                  end
                  scan_seq_pkg::PH_CARRY: begin
                     r_nxt.sec[s].cnt = cnt_inc;
                     r_nxt.sec[s].carry = 1'b0;
                     r_nxt.sec[s].out_en = 1'b0;
                     r_nxt.sec[s].phase = scan_seq_pkg::PH_IDLE;
                  end
                  default: begin
                     // an upset phase code parks the section with its output floated
                     r_nxt.sec[s].phase = scan_seq_pkg::PH_IDLE;
                     r_nxt.sec[s].carry = 1'b0;
                     r_nxt.sec[s].out_en = 1'b0;
                  end
               endcase
            end
            // integrator reset lasts until edge 19, i.e. 18 clocks after capture
            // a freeze in the same cycle keeps the reset running, the set wins
            if (r.sec[s].in_reset && !start_eff && r.sec[s].phase != scan_seq_pkg::PH_IDLE
                && cnt_inc == scan_seq_pkg::CNT_INTEG && !frz_rise) begin
               r_nxt.sec[s].in_reset = 1'b0;
               r_nxt.sec[s].integ = 1'b1;
            end
         end
         // drive the next pixel word, flag an empty buffer
         if (pop_req[s]) begin
            if (fifo_valid[s]) begin
               r_nxt.sec[s].data = fifo_data[s];
            end else begin
               r_nxt.sec[s].underrun = 1'b1;
            end
         end
      end
      if (!en_i) begin
         r_nxt = r;
         pop_req = '0;
      end
   end

   // state register
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         r <= STATE_RST;
      end else begin
         r <= r_nxt;
      end
   end

   // gather the state flops by section
   for (genvar s = 0; s < NS; s++) begin : g_view
      assign pix_q[s] = r.sec[s].data;
      assign oe_q[s] = r.sec[s].out_en;
      assign carry_q[s] = r.sec[s].carry;
      assign hold_q[s] = r.sec[s].hold;
      assign integ_q[s] = r.sec[s].integ;
      assign under_q[s] = r.sec[s].underrun;
   end

   // outputs straight from the state flops
   assign section1_pixel_voltage_out_o = pix_q[0];
   assign section2_pixel_voltage_out_o = pix_q[1];
   assign section1_pixel_voltage_oe_o = oe_q[0];
   assign section2_pixel_voltage_oe_o = oe_q[1];
   assign section1_scan_carry_out_o = carry_q[0];
   assign section2_scan_carry_out_o = carry_q[1];
   assign section1_hold_pulse_o = hold_q[0];
   assign section2_hold_pulse_o = hold_q[1];
   assign section1_integrating_o = integ_q[0];
   assign section2_integrating_o = integ_q[1];
   assign section1_underrun_o = under_q[0];
   assign section2_underrun_o = under_q[1];
endmodule : linear_pixel_array_scan_sequencer

// >>> test/scan_seq_monitor.sv
// port-level assertions for the scan sequencer
`timescale 1ns/1ps
module scan_seq_monitor (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic chain_serial_i,
   input wire logic section1_pixel_voltage_oe_o,
   input wire logic section2_pixel_voltage_oe_o,
   input wire logic section1_scan_carry_out_o,
   input wire logic section2_scan_carry_out_o,
   input wire logic section1_hold_pulse_o,
   input wire logic section2_hold_pulse_o,
   input wire logic section1_integrating_o
);
   // one domain: system clock, async reset
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   carry_one_phase_a:
      assert property (section1_scan_carry_out_o |-> section1_pixel_voltage_oe_o)
      else $error("carry one outside output phase");
   carry_two_phase_a:
      assert property (section2_scan_carry_out_o |-> section2_pixel_voltage_oe_o)
      else $error("carry two outside output phase");
   carry_end_float_a:
      assert property ($fell(section1_scan_carry_out_o) |-> !section1_pixel_voltage_oe_o)
      else $error("output still driven after carry end");
   carry_min_len_a:
      assert property ($rose(section1_scan_carry_out_o) |=> section1_scan_carry_out_o)
      else $error("carry one shorter than two cycles");
   hold_one_cycle_a:
      assert property (section1_hold_pulse_o |=> !section1_hold_pulse_o)
      else $error("hold pulse longer than one cycle");
   hold_stops_integ_a:
      assert property (section1_hold_pulse_o |=> !section1_integrating_o)
      else $error("integration not stopped by freeze");
   chain_start_a:
      assert property (chain_serial_i && $fell(section1_scan_carry_out_o)
         |-> ##[0:4] section2_pixel_voltage_oe_o)
      else $error("section two not started by carry one");
   integ_in_phase_a:
      assert property ($rose(section1_integrating_o) |-> section1_pixel_voltage_oe_o)
      else $error("integration began outside readout");
   hold_two_len_a:
      assert property (section2_hold_pulse_o |=> !section2_hold_pulse_o)
      else $error("hold pulse two longer than one cycle");
   hold_chain_a:
      assert property (chain_serial_i && section1_hold_pulse_o |-> section2_hold_pulse_o)
      else $error("serial freeze did not reach section two");
endmodule : scan_seq_monitor

bind linear_pixel_array_scan_sequencer scan_seq_monitor scan_seq_monitor_inst (
   .clk_i, .rst_i, .chain_serial_i, .section1_pixel_voltage_oe_o,
   .section2_pixel_voltage_oe_o, .section1_scan_carry_out_o, .section2_scan_carry_out_o,
   .section1_hold_pulse_o, .section2_hold_pulse_o, .section1_integrating_o);

// >>> test/scan_ctrl_model.sv
// behavioural controller making shift clock and start pulse for one section
`timescale 1ns/1ps
module scan_ctrl_model #(
   parameter int XFER_NS = 1000
) (
   input wire logic go_i,
   input wire logic with_start_i,
   input wire logic [11:0] n_i,
   output logic sck_o,
   output logic start_o,
   output logic freeze_o,
   output logic busy_o
);
   // freeze tied to own start
   assign freeze_o = start_o;
   initial begin
      sck_o = 1'b0;
      start_o = 1'b0;
      busy_o = 1'b0;
   end
   // one frame per go, clock stands still between frames
   always @(posedge go_i) begin
      busy_o = 1'b1;
      start_o = with_start_i;
      #110;
      for (int i = 1; i <= int'(n_i); i++) begin
         sck_o = 1'b1;
         #100;
         start_o = 1'b0;
         #100;
         sck_o = 1'b0;
         #200;
      end
      #XFER_NS;
      busy_o = 1'b0;
   end
endmodule : scan_ctrl_model

// >>> test/testbench.sv
// self-checking bench for the scan sequencer
`timescale 1ns/1ps
module testbench;
   logic clk_i = 1'b0, rst_i = 1'b1, en_i = 1'b1, chain_serial_i = 1'b0;
   logic section1_shift_clock_i, section2_shift_clock_i, ck2, b1, b2, t1, t2;
   logic section1_scan_start_in_i, section2_scan_start_in_i;
   logic section1_freeze_strobe_i, section2_freeze_strobe_i;
   logic [scan_seq_pkg::DATA_W-1:0] section1_sample_data_i, section2_sample_data_i;
   logic [scan_seq_pkg::DATA_W-1:0] section1_pixel_voltage_out_o, section2_pixel_voltage_out_o;
   logic section1_sample_valid_i = 1'b0, section2_sample_valid_i = 1'b0;
   logic section1_sample_ready_o, section2_sample_ready_o;
   logic section1_pixel_voltage_oe_o, section2_pixel_voltage_oe_o;
   logic section1_scan_carry_out_o, section2_scan_carry_out_o;
   logic section1_hold_pulse_o, section2_hold_pulse_o;
   logic section1_integrating_o, section2_integrating_o;
   logic section1_underrun_o, section2_underrun_o;
   logic go1 = 1'b0, go2 = 1'b0, ws = 1'b1;
   logic [11:0] n = 12'h000;
   int d1 = 0, d2 = 0, n_mismatch = 0, comparisons = 0;
   int base[3] = '{0, 0, 0};
   int lim[3];
   linear_pixel_array_scan_sequencer linear_pixel_array_scan_sequencer_inst (.*);
   scan_ctrl_model scan_ctrl_model_inst (.go_i(go1), .with_start_i(ws), .n_i(n),
      .sck_o(section1_shift_clock_i), .start_o(section1_scan_start_in_i),
      .freeze_o(section1_freeze_strobe_i), .busy_o(b1));
   scan_ctrl_model scan_ctrl_model_inst2 (.go_i(go2), .with_start_i(ws), .n_i(n),
      .sck_o(ck2), .start_o(section2_scan_start_in_i),
      .freeze_o(section2_freeze_strobe_i), .busy_o(b2));
   // serial chaining shares the first shift clock
   assign section2_shift_clock_i = chain_serial_i ? section1_shift_clock_i : ck2;
   assign section1_sample_data_i = d1[11:0];
   assign section2_sample_data_i = d2[11:0];
   always #25 clk_i = ~clk_i;
   // sample words advance after each accepted handshake
   always @(posedge clk_i) begin
      t1 <= section1_sample_valid_i & section1_sample_ready_o & en_i;
      t2 <= section2_sample_valid_i & section2_sample_ready_o & en_i;
   end
   always @(negedge clk_i) begin
      if (t1) d1 <= d1 + 1;
      if (t2) d2 <= d2 + 1;
   end
   task automatic tally_and_finish;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : tally_and_finish
   task automatic cmp(input logic [15:0] g, input logic [15:0] e);
      comparisons++;
      if (g !== e) begin
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
         n_mismatch++;
      end
   endtask : cmp
   task automatic give_up;
      $display("wait limit reached at t=%0t", $time);
      n_mismatch++;
      tally_and_finish();
   endtask : give_up
   // bounded wait for the next rise of a shift clock pin
   task automatic wait_rise(input int s);
      int c;
      c = 0;
      while ((s == 2 ? ck2 : section1_shift_clock_i) !== 1'b0 && c < 20) begin
         @(negedge clk_i);
         c++;
      end
      while ((s == 2 ? ck2 : section1_shift_clock_i) !== 1'b1 && c < 20) begin
         @(negedge clk_i);
         c++;
      end
      if (c >= 20) give_up();
   endtask : wait_rise
   // state of section s after its shift edge p
   task automatic sec(input int s, input int p);
      logic [15:0] v;
      int w;
      v = s == 1 ? {section1_pixel_voltage_oe_o, section1_scan_carry_out_o,
         section1_integrating_o, section1_underrun_o, section1_pixel_voltage_out_o}
         : {section2_pixel_voltage_oe_o, section2_scan_carry_out_o,
         section2_integrating_o, section2_underrun_o, section2_pixel_voltage_out_o};
      w = p < lim[s] ? p : lim[s];
      cmp(v[15], p >= 1 && p <= 640);
      cmp(v[14], p == 640);
      if (p >= 2) cmp(v[13], p >= 19);
      if (p >= 1) cmp(v[12], p > lim[s]);
      if (p >= 1 && p <= 640) cmp(v[11:0], 12'(base[s] + w - 1));
   endtask : sec
   task automatic chk(input int m, input int e);
      if (m != 2) sec(1, e);
      if (m != 1) sec(2, m == 3 ? e - 640 : e);
   endtask : chk
   // one frame: mode 1 or 2 a single section, mode 3 serial
   task automatic frame(input int m, input int nn, input logic st);
      int c;
      lim[1] = section1_sample_valid_i ? 99999 : d1 - base[1];
      lim[2] = section2_sample_valid_i ? 99999 : d2 - base[2];
      n = 12'(nn);
      ws = st;
      if (m == 2) go2 = 1'b1;
      else go1 = 1'b1;
      @(negedge clk_i);
      go1 = 1'b0;
      go2 = 1'b0;
      for (int e = 0; e < nn; e++) begin
         wait_rise(m == 2 ? 2 : 1);
         if (st) chk(m, e);
      end
      c = 0;
      while ((m == 2 ? b2 : b1) !== 1'b0 && c < 200) begin
         @(negedge clk_i);
         c++;
      end
      if (c >= 200) give_up();
      chk(m, st ? nn : 0);
      if (st && m != 2) base[1] += lim[1] < 640 ? lim[1] : 640;
      if (st && m != 1) base[2] += lim[2] < 640 ? lim[2] : 640;
   endtask : frame
   task automatic fill_refuse;
      section1_sample_valid_i = 1'b1;
      section2_sample_valid_i = 1'b1;
      repeat (30) @(negedge clk_i);
      cmp(section1_sample_ready_o, 1'b0);
      cmp(section2_sample_ready_o, 1'b0);
      cmp(d1, 16);
      cmp(d2, 16);
   endtask : fill_refuse
   task automatic parallel_scan;
      frame(1, 641, 1'b1);
      frame(2, 641, 1'b1);
   endtask : parallel_scan
   task automatic serial_scan;
      chain_serial_i = 1'b1;
      repeat (4) @(negedge clk_i);
      frame(3, 1281, 1'b1);
      chain_serial_i = 1'b0;
      repeat (4) @(negedge clk_i);
   endtask : serial_scan
   task automatic underrun_recover;
      section1_sample_valid_i = 1'b0;
      repeat (2) @(negedge clk_i);
      frame(1, 641, 1'b1);
      section1_sample_valid_i = 1'b1;
      repeat (30) @(negedge clk_i);
      frame(1, 641, 1'b1);
   endtask : underrun_recover
   // enable low: a start and clock burst must leave section one untouched
   task automatic enable_hold;
      int c;
      int d;
      d = d1;
      en_i = 1'b0;
      n = 12'h003;
      ws = 1'b1;
      go1 = 1'b1;
      @(negedge clk_i);
      go1 = 1'b0;
      c = 0;
      while (b1 !== 1'b0 && c < 200) begin
         @(negedge clk_i);
         c++;
      end
      if (c >= 200) give_up();
      cmp(section1_pixel_voltage_oe_o, 1'b0);
      cmp(section1_integrating_o, 1'b1);
      cmp(section1_scan_carry_out_o, 1'b0);
      cmp(16'(d1), 16'(d));
      en_i = 1'b1;
      repeat (4) @(negedge clk_i);
   endtask : enable_hold
   // main sequence
   initial begin
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      rst_i = 1'b0;
      fill_refuse();
      frame(1, 5, 1'b0);
      parallel_scan();
      serial_scan();
      underrun_recover();
      enable_hold();
      tally_and_finish();
   end
endmodule : testbench
